//--- core/dmpw_pkg.sv
// constants shared by the multiply-accumulate prefetch/write-back unit
// assumes one core clock and a decoder that presents decoded fields
`default_nettype none

package dmpw_pkg;
  // ----------
  // widths and field positions
  // ----------
  localparam int ACC_W = 40;
  localparam int WORD_W = 16;
  localparam int HIGH_LSB = 16;
  localparam int UPPER_LSB = 32;

  // ----------
  // operation codes
  // ----------
  localparam logic [2:0] OP_CLR = 3'h0;
  localparam logic [2:0] OP_MOVSTORE = 3'h1;
  localparam logic [2:0] OP_MAC = 3'h2;
  localparam logic [2:0] OP_MSUB = 3'h3;
  localparam logic [2:0] OP_MUL = 3'h4;
  localparam logic [2:0] OP_NMUL = 3'h5;
  localparam logic [2:0] OP_EDIST = 3'h6;
  localparam logic [2:0] OP_EDIST_ACC = 3'h7;

  // ----------
  // prefetch, write-back and saturation modes
  // ----------
  localparam logic [1:0] PF_NONE = 2'h0;
  localparam logic [1:0] PF_POST = 2'h1;
  localparam logic [1:0] PF_OFFSET = 2'h2;
  localparam logic [2:0] PF_MOD_BAD = 3'h4;
  localparam logic [1:0] WB_NONE = 2'h0;
  localparam logic [1:0] WB_DIRECT = 2'h1;
  localparam logic [1:0] WB_INDIRECT = 2'h2;
  localparam logic [1:0] SAT_OFF = 2'h0;
  localparam logic [1:0] SAT_NORMAL = 2'h1;
  localparam logic [1:0] SAT_SUPER = 2'h2;

  // ----------
  // accumulator register indices
  // ----------
  localparam logic [2:0] SFR_A_UPPER = 3'h0;
  localparam logic [2:0] SFR_A_HIGH = 3'h1;
  localparam logic [2:0] SFR_A_LOW = 3'h2;
  localparam logic [2:0] SFR_B_UPPER = 3'h3;
  localparam logic [2:0] SFR_B_HIGH = 3'h4;
  localparam logic [2:0] SFR_B_LOW = 3'h5;

  // ----------
  // values
  // ----------
  localparam logic [39:0] ACC_RST = 40'h00_0000_0000;
  localparam logic [39:0] ROUND_BIAS = 40'h00_0000_8000;
  localparam logic [39:0] SAT32_POS = 40'h00_7fff_ffff;
  localparam logic [39:0] SAT32_NEG = 40'hff_8000_0000;
  localparam logic [39:0] SAT40_POS = 40'h7f_ffff_ffff;
  localparam logic [39:0] SAT40_NEG = 40'h80_0000_0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] WB_POST_INC = 16'h0002;
endpackage : dmpw_pkg

`default_nettype wire

//--- core/dmpw_pf_if.sv
// bundle between the unit and one prefetch address generator
// assumes combinational use inside one clock domain
`timescale 1ns/1ps
`default_nettype none

interface dmpw_pf_if;
  logic [1:0] mode;
  logic [15:0] base;
  logic [15:0] offset;
  logic [2:0] modify;
  logic [15:0] addr;
  logic [15:0] new_ptr;
  logic upd;
  logic en;

  modport gen (
    input mode, base, offset, modify,
    output addr, new_ptr, upd, en
  );
  modport user (
    output mode, base, offset, modify,
    input addr, new_ptr, upd, en
  );
endinterface : dmpw_pf_if

`default_nettype wire

//--- core/dmpw_pf_gen.sv
// prefetch address and pointer post-modify generator, one per data bus
// assumes the caller has already refused illegal mode/modify codes
`timescale 1ns/1ps
`default_nettype none

module dmpw_pf_gen (
  dmpw_pf_if.gen pf
);
  // ------------------------------------------------------------
  // address and pointer update
  // ------------------------------------------------------------
  wire [15:0] step_bytes;
  wire ofs_mode;

  assign step_bytes = {{12{pf.modify[2]}}, pf.modify, 1'b0};
  assign ofs_mode = (pf.mode == dmpw_pkg::PF_OFFSET);
  assign pf.en = (pf.mode != dmpw_pkg::PF_NONE);
  assign pf.addr = ofs_mode ? pf.base + pf.offset : pf.base;
  assign pf.new_ptr = pf.base + step_bytes;
  assign pf.upd = (pf.mode == dmpw_pkg::PF_POST) && (pf.modify != 3'h0);
endmodule : dmpw_pf_gen

`default_nettype wire

//--- core/dmpw_unit.sv
// multiply-accumulate datapath with dual prefetch and write-back
// assumes decoded fields, register values and x/y memory
// returning read data in the same clock as the registered address
// Operation
// - six accumulator parts are addressable registers
// - upper byte reads back sign-extended to 16
// - moves never touch overflow or saturation flags
// - double-word accumulator load and store
// - two reads, two updates, one op per cycle
// - x pointer w8/w9, y w10/w11, dest w4-w7
// - offset mode: base plus w12, w9/w11 only
// - post-modify by -6..+6 even bytes
// - offset mode leaves base and offset unchanged
// - operands from w4-w7, same register squares
// - multiply then add, subtract or store
// - distance ops need equal operands, store difference
// - clear zeroes accumulator, no multiplier
// - move-and-store prefetches and stores, no multiplier
// - rounded alternate stored via w13, direct or +2
// - write-back only on clear, move, msub, mac with distinct operands
// - write-back accumulator is always the other one
// - multiply ops name accumulator and two operands
// - control bit 0 fractional, 1 integer
// - fractional product shifted left one bit
// - normal saturation keeps upper byte as sign
`timescale 1ns/1ps
`default_nettype none

module dmpw_unit (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic op_acc_sel_in,
  input wire logic [1:0] op_mul_a_in,
  input wire logic [1:0] op_mul_b_in,
  input wire logic [1:0] x_pf_mode_in,
  input wire logic x_pf_ptr_in,
  input wire logic [2:0] x_pf_mod_in,
  input wire logic [1:0] x_pf_dst_in,
  input wire logic [1:0] y_pf_mode_in,
  input wire logic y_pf_ptr_in,
  input wire logic [2:0] y_pf_mod_in,
  input wire logic [1:0] y_pf_dst_in,
  input wire logic [1:0] wb_mode_in,
  input wire logic [15:0] w4_in,
  input wire logic [15:0] w5_in,
  input wire logic [15:0] w6_in,
  input wire logic [15:0] w7_in,
  input wire logic [15:0] w8_in,
  input wire logic [15:0] w9_in,
  input wire logic [15:0] w10_in,
  input wire logic [15:0] w11_in,
  input wire logic [15:0] w12_in,
  input wire logic [15:0] w13_in,
  input wire logic frac_int_mode_in,
  input wire logic [1:0] sat_mode_in,
  input wire logic [1:0] sat_flag_clr_in,
  input wire logic [15:0] x_rdata_in,
  input wire logic [15:0] y_rdata_in,
  input wire logic sfr_rd_in,
  input wire logic sfr_wr_in,
  input wire logic [2:0] sfr_sel_in,
  input wire logic [1:0] sfr_be_in,
  input wire logic [15:0] sfr_wdata_in,
  input wire logic dbl_load_in,
  input wire logic dbl_store_in,
  input wire logic dbl_acc_in,
  input wire logic [31:0] dbl_wdata_in,
  output logic x_rd_out,
  output logic [15:0] x_addr_out,
  output logic y_rd_out,
  output logic [15:0] y_addr_out,
  output logic xptr_wr_out,
  output logic xptr_sel_out,
  output logic [15:0] xptr_val_out,
  output logic yptr_wr_out,
  output logic yptr_sel_out,
  output logic [15:0] yptr_val_out,
  output logic pf_x_wr_out,
  output logic [1:0] pf_x_dst_out,
  output logic [15:0] pf_x_val_out,
  output logic pf_y_wr_out,
  output logic [1:0] pf_y_dst_out,
  output logic [15:0] pf_y_val_out,
  output logic wb_mem_wr_out,
  output logic [15:0] wb_addr_out,
  output logic [15:0] wb_data_out,
  output logic w13_wr_out,
  output logic [15:0] w13_val_out,
  output logic [15:0] sfr_rdata_out,
  output logic [31:0] dbl_rdata_out,
  output logic acc_a_overflow_flag_out,
  output logic acc_b_overflow_flag_out,
  output logic acc_a_saturated_flag_out,
  output logic acc_b_saturated_flag_out,
  output logic op_err_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [39:0] acc_r [0:1];
  logic [39:0] acc_nxt [0:1];
  logic [1:0] ov_r;
  logic [1:0] ov_nxt;
  logic [1:0] sat_r;
  logic [1:0] sat_nxt;
  logic pend_x_r;
  logic pend_y_r;
  logic pend_ed_r;
  logic [1:0] pend_xdst_r;
  logic [1:0] pend_ydst_r;

  // ------------------------------------------------------------
  // decode and refusal
  // ------------------------------------------------------------
  wire [15:0] wsrc [0:3];
  wire [15:0] mul_a;
  wire [15:0] mul_b;
  wire same_src;
  wire ed_op;
  wire mul_op;
  wire acc_op;
  wire x_bad;
  wire y_bad;
  wire ed_bad;
  wire wb_ok_op;
  wire wb_bad;
  wire op_bad;
  wire go;

  assign wsrc[0] = w4_in;
  assign wsrc[1] = w5_in;
  assign wsrc[2] = w6_in;
  assign wsrc[3] = w7_in;
  assign mul_a = wsrc[op_mul_a_in];
  assign mul_b = wsrc[op_mul_b_in];
  assign same_src = (op_mul_a_in == op_mul_b_in);
  assign ed_op = (op_code_in == dmpw_pkg::OP_EDIST) ||
                 (op_code_in == dmpw_pkg::OP_EDIST_ACC);
  assign mul_op = (op_code_in != dmpw_pkg::OP_CLR) &&
                  (op_code_in != dmpw_pkg::OP_MOVSTORE);
  assign acc_op = (op_code_in != dmpw_pkg::OP_MOVSTORE);
  assign x_bad = (x_pf_mode_in == 2'h3) ||
                 ((x_pf_mode_in == dmpw_pkg::PF_OFFSET) && !x_pf_ptr_in) ||
                 ((x_pf_mode_in == dmpw_pkg::PF_POST) &&
                  (x_pf_mod_in == dmpw_pkg::PF_MOD_BAD));
  assign y_bad = (y_pf_mode_in == 2'h3) ||
                 ((y_pf_mode_in == dmpw_pkg::PF_OFFSET) && !y_pf_ptr_in) ||
                 ((y_pf_mode_in == dmpw_pkg::PF_POST) &&
                  (y_pf_mod_in == dmpw_pkg::PF_MOD_BAD));
  assign ed_bad = ed_op && (!same_src ||
                  (x_pf_mode_in == dmpw_pkg::PF_NONE) ||
                  (y_pf_mode_in == dmpw_pkg::PF_NONE));
  assign wb_ok_op = (op_code_in == dmpw_pkg::OP_CLR) ||
                    (op_code_in == dmpw_pkg::OP_MOVSTORE) ||
                    (op_code_in == dmpw_pkg::OP_MSUB) ||
                    ((op_code_in == dmpw_pkg::OP_MAC) && !same_src);
  assign wb_bad = (wb_mode_in == 2'h3) ||
                  ((wb_mode_in != dmpw_pkg::WB_NONE) && !wb_ok_op);
  assign op_bad = x_bad || y_bad || ed_bad || wb_bad;
  // refused instructions only raise op_err_out, with no strobe, flag or accumulator change
  assign go = op_valid_in && !op_bad;

  // ------------------------------------------------------------
  // prefetch address generators
  // ------------------------------------------------------------
  dmpw_pf_if pfx ();
  dmpw_pf_if pfy ();

  // x from w8/w9, y from w10/w11
  assign pfx.mode = x_pf_mode_in;
  assign pfx.base = x_pf_ptr_in ? w9_in : w8_in;
  assign pfx.offset = w12_in;
  assign pfx.modify = x_pf_mod_in;
  assign pfy.mode = y_pf_mode_in;
  assign pfy.base = y_pf_ptr_in ? w11_in : w10_in;
  assign pfy.offset = w12_in;
  assign pfy.modify = y_pf_mod_in;

  dmpw_pf_gen u_pfx (
    .pf (pfx)
  );
  dmpw_pf_gen u_pfy (
    .pf (pfy)
  );

  // ------------------------------------------------------------
  // multiply, accumulate, saturate
  // ------------------------------------------------------------
  wire signed [31:0] prod_raw;
  wire [40:0] prod41;
  wire [39:0] acc_cur;
  wire [40:0] acc41;
  logic [40:0] sum41;
  wire norm_ovf;
  wire sup_ovf;
  wire [39:0] res40;
  wire sat_hit;
  wire res_ov;

  assign prod_raw = $signed(mul_a) * $signed(mul_b);
  assign prod41 = frac_int_mode_in ? {{9{prod_raw[31]}}, prod_raw} :
                  {{8{prod_raw[31]}}, prod_raw, 1'b0};
  assign acc_cur = acc_r[op_acc_sel_in];
  assign acc41 = {acc_cur[39], acc_cur};

  always_comb begin
    case (op_code_in)
      dmpw_pkg::OP_CLR: sum41 = 41'h000_0000_0000;
      dmpw_pkg::OP_MAC: sum41 = acc41 + prod41;
      dmpw_pkg::OP_EDIST_ACC: sum41 = acc41 + prod41;
      dmpw_pkg::OP_MSUB: sum41 = acc41 - prod41;
      dmpw_pkg::OP_MUL: sum41 = prod41;
      dmpw_pkg::OP_EDIST: sum41 = prod41;
      dmpw_pkg::OP_NMUL: sum41 = 41'h000_0000_0000 - prod41;
      default: sum41 = acc41;
    endcase
  end

  // normal mode clips to 32 bits
  assign norm_ovf = !((&sum41[40:31]) || !(|sum41[40:31]));
  assign sup_ovf = sum41[40] ^ sum41[39];
  assign sat_hit = (sat_mode_in == dmpw_pkg::SAT_NORMAL) ? norm_ovf :
                   (sat_mode_in == dmpw_pkg::SAT_SUPER) ? sup_ovf : 1'b0;
  assign res40 =
    !sat_hit ? sum41[39:0] :
    (sat_mode_in == dmpw_pkg::SAT_NORMAL) ?
      (sum41[40] ? dmpw_pkg::SAT32_NEG : dmpw_pkg::SAT32_POS) :
      (sum41[40] ? dmpw_pkg::SAT40_NEG : dmpw_pkg::SAT40_POS);
  // guard bits in use means overflow past bit 31
  assign res_ov = !((&res40[39:31]) || !(|res40[39:31]));

  // ------------------------------------------------------------
  // write-back of the alternate accumulator
  // ------------------------------------------------------------
  wire [39:0] alt_acc;
  wire [39:0] alt_rnd;
  wire wb_dir;
  wire wb_ind;

  assign alt_acc = acc_r[!op_acc_sel_in];
  // no clipping: 0x7fff_8000 and above round over into the sign bit
  assign alt_rnd = alt_acc + dmpw_pkg::ROUND_BIAS;
  assign wb_dir = go && (wb_mode_in == dmpw_pkg::WB_DIRECT);
  assign wb_ind = go && (wb_mode_in == dmpw_pkg::WB_INDIRECT);

  // ------------------------------------------------------------
  // memory-mapped accumulator access
  // ------------------------------------------------------------
  wire sfr_ok;
  wire sfr_acc;
  wire [1:0] sfr_part;
  wire [39:0] sfr_cur;
  wire [15:0] sfr_view;
  wire [15:0] sfr_merge;
  wire [39:0] sfr_new;
  wire [39:0] dbl_new;

  assign sfr_ok = (sfr_sel_in <= dmpw_pkg::SFR_B_LOW);
  assign sfr_acc = (sfr_sel_in >= dmpw_pkg::SFR_B_UPPER);
  assign sfr_part = sfr_acc ? 2'(sfr_sel_in - dmpw_pkg::SFR_B_UPPER) :
                    sfr_sel_in[1:0];
  assign sfr_cur = acc_r[sfr_acc];
  assign sfr_view = !sfr_ok ? dmpw_pkg::WORD_RST :
    (sfr_part == 2'h0) ? {{8{sfr_cur[39]}}, sfr_cur[39:32]} :
    (sfr_part == 2'h1) ? sfr_cur[31:16] : sfr_cur[15:0];
  assign sfr_merge = {sfr_be_in[1] ? sfr_wdata_in[15:8] : sfr_view[15:8],
                      sfr_be_in[0] ? sfr_wdata_in[7:0] : sfr_view[7:0]};
  assign sfr_new =
    (sfr_part == 2'h0) ? {sfr_merge[7:0], sfr_cur[31:0]} :
    (sfr_part == 2'h1) ? {sfr_cur[39:32], sfr_merge, sfr_cur[15:0]} :
    {sfr_cur[39:16], sfr_merge};
  // load high and low at once
  assign dbl_new = {{8{dbl_wdata_in[31]}}, dbl_wdata_in};

  // dsp result wins over a move to the same accumulator
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      acc_nxt[i] = acc_r[i];
      ov_nxt[i] = ov_r[i];
      // sticky, set wins over clear
      sat_nxt[i] = sat_r[i] && !sat_flag_clr_in[i];
      if (go && acc_op && (op_acc_sel_in == 1'(i))) begin
        acc_nxt[i] = res40;
        ov_nxt[i] = res_ov;
        sat_nxt[i] = sat_nxt[i] || sat_hit;
      end else if (dbl_load_in && (dbl_acc_in == 1'(i))) begin
        acc_nxt[i] = dbl_new;
      end else if (sfr_wr_in && sfr_ok && (sfr_acc == 1'(i))) begin
        acc_nxt[i] = sfr_new;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // issue every cycle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      acc_r[0] <= dmpw_pkg::ACC_RST;
      acc_r[1] <= dmpw_pkg::ACC_RST;
      ov_r <= 2'h0;
      sat_r <= 2'h0;
    end else begin
      acc_r[0] <= acc_nxt[0];
      acc_r[1] <= acc_nxt[1];
      ov_r <= ov_nxt;
      sat_r <= sat_nxt;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      x_rd_out <= 1'b0;
      y_rd_out <= 1'b0;
      x_addr_out <= dmpw_pkg::WORD_RST;
      y_addr_out <= dmpw_pkg::WORD_RST;
      xptr_wr_out <= 1'b0;
      yptr_wr_out <= 1'b0;
      xptr_sel_out <= 1'b0;
      yptr_sel_out <= 1'b0;
      xptr_val_out <= dmpw_pkg::WORD_RST;
      yptr_val_out <= dmpw_pkg::WORD_RST;
    end else begin
      x_rd_out <= go && pfx.en;
      y_rd_out <= go && pfy.en;
      x_addr_out <= pfx.addr;
      y_addr_out <= pfy.addr;
      xptr_wr_out <= go && pfx.upd;
      yptr_wr_out <= go && pfy.upd;
      xptr_sel_out <= x_pf_ptr_in;
      yptr_sel_out <= y_pf_ptr_in;
      xptr_val_out <= pfx.new_ptr;
      yptr_val_out <= pfy.new_ptr;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pend_x_r <= 1'b0;
      pend_y_r <= 1'b0;
      pend_ed_r <= 1'b0;
      pend_xdst_r <= 2'h0;
      pend_ydst_r <= 2'h0;
      pf_x_wr_out <= 1'b0;
      pf_y_wr_out <= 1'b0;
      pf_x_dst_out <= 2'h0;
      pf_y_dst_out <= 2'h0;
      pf_x_val_out <= dmpw_pkg::WORD_RST;
      pf_y_val_out <= dmpw_pkg::WORD_RST;
    end else begin
      pend_x_r <= go && pfx.en;
      pend_y_r <= go && pfy.en;
      pend_ed_r <= go && ed_op;
      pend_xdst_r <= x_pf_dst_in;
      pend_ydst_r <= y_pf_dst_in;
      pf_x_wr_out <= pend_x_r;
      pf_y_wr_out <= pend_y_r && !pend_ed_r;
      pf_x_dst_out <= pend_xdst_r;
      pf_y_dst_out <= pend_ydst_r;
      pf_x_val_out <= pend_ed_r ? x_rdata_in - y_rdata_in : x_rdata_in;
      pf_y_val_out <= y_rdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      wb_mem_wr_out <= 1'b0;
      wb_addr_out <= dmpw_pkg::WORD_RST;
      wb_data_out <= dmpw_pkg::WORD_RST;
      w13_wr_out <= 1'b0;
      w13_val_out <= dmpw_pkg::WORD_RST;
    end else begin
      wb_mem_wr_out <= wb_ind;
      wb_addr_out <= w13_in;
      wb_data_out <= alt_rnd[31:16];
      w13_wr_out <= wb_dir || wb_ind;
      w13_val_out <= wb_ind ? w13_in + dmpw_pkg::WB_POST_INC :
                     alt_rnd[31:16];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sfr_rdata_out <= dmpw_pkg::WORD_RST;
      dbl_rdata_out <= 32'h0000_0000;
      op_err_out <= 1'b0;
    end else begin
      if (sfr_rd_in) begin
        sfr_rdata_out <= sfr_view;
      end
      // store high and low at once
      if (dbl_store_in) begin
        dbl_rdata_out <= acc_r[dbl_acc_in][31:0];
      end
      op_err_out <= op_valid_in && op_bad;
    end
  end

  assign acc_a_overflow_flag_out = ov_r[0];
  assign acc_b_overflow_flag_out = ov_r[1];
  assign acc_a_saturated_flag_out = sat_r[0];
  assign acc_b_saturated_flag_out = sat_r[1];
endmodule : dmpw_unit

`default_nettype wire

//--- test/dmpw_unit_properties.sv
// port assertions for the mac prefetch/write-back unit
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module dmpw_props (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic op_valid_in,
  input wire logic [2:0] op_code_in,
  input wire logic [1:0] x_pf_mode_in,
  input wire logic [2:0] x_pf_mod_in,
  input wire logic [1:0] wb_mode_in,
  input wire logic sfr_rd_in,
  input wire logic sfr_wr_in,
  input wire logic [2:0] sfr_sel_in,
  input wire logic x_rd_out,
  input wire logic xptr_wr_out,
  input wire logic pf_x_wr_out,
  input wire logic wb_mem_wr_out,
  input wire logic [15:0] wb_addr_out,
  input wire logic w13_wr_out,
  input wire logic [15:0] w13_val_out,
  input wire logic [15:0] sfr_rdata_out,
  input wire logic acc_a_overflow_flag_out,
  input wire logic op_err_out
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  rd_after_op_a: assert property (
    x_rd_out |-> $past(op_valid_in)) else $error("read without op");
  pf_after_rd_a: assert property (
    x_rd_out |=> pf_x_wr_out) else $error("no prefetch write");
  ptr_with_rd_a: assert property (
    xptr_wr_out |-> x_rd_out) else $error("pointer moved alone");
  offset_keep_a: assert property (
    op_valid_in && x_pf_mode_in == dmpw_pkg::PF_OFFSET |=> !xptr_wr_out)
    else $error("offset moved pointer");
  modify_bad_a: assert property (
    op_valid_in && x_pf_mode_in == dmpw_pkg::PF_POST &&
    x_pf_mod_in == dmpw_pkg::PF_MOD_BAD |=> op_err_out && !x_rd_out)
    else $error("bad modify taken");
  wb_refused_a: assert property (
    op_valid_in && op_code_in[2] && wb_mode_in != dmpw_pkg::WB_NONE
    |=> op_err_out && !wb_mem_wr_out) else $error("write-back taken");
  wb_post_inc_a: assert property (
    wb_mem_wr_out |-> w13_wr_out &&
    w13_val_out == wb_addr_out + dmpw_pkg::WB_POST_INC)
    else $error("pointer not stepped by 2");
  upper_sext_a: assert property (
    $past(sfr_rd_in && sfr_sel_in == dmpw_pkg::SFR_A_UPPER) |->
    sfr_rdata_out[15:8] == {8{sfr_rdata_out[7]}})
    else $error("upper not extended");
  move_flag_a: assert property (
    sfr_wr_in && !op_valid_in |=> $stable(acc_a_overflow_flag_out))
    else $error("move changed flag");

  cover property (x_rd_out ##1 pf_x_wr_out);
  cover property (wb_mem_wr_out);
  cover property (op_err_out);
endmodule : dmpw_props
`default_nettype wire

//--- test/dmpw_mem_model.sv
// x and y data memory seen by the prefetch buses
// assumes read data is wanted in the cycle the read pulse stands
`timescale 1ns/1ps
`default_nettype none
module dmpw_mem_model (
  input wire logic sys_clk_in,
  input wire logic x_rd_out,
  input wire logic [15:0] x_addr_out,
  input wire logic y_rd_out,
  input wire logic [15:0] y_addr_out,
  output logic [15:0] x_rdata_in,
  output logic [15:0] y_rdata_in
);
  logic [15:0] x_last_r = 16'h0000;
  logic [15:0] y_last_r = 16'h0000;
  // idle buses flip every cycle so stale data never looks valid
  assign x_rdata_in = x_rd_out ? x_addr_out + 16'h0100 : ~x_last_r;
  assign y_rdata_in = y_rd_out ? y_addr_out - 16'h0100 : ~y_last_r;
  always @(posedge sys_clk_in) begin
    x_last_r <= x_rdata_in;
    y_last_r <= y_rdata_in;
  end
endmodule : dmpw_mem_model
`default_nettype wire

//--- test/tb_dmpw_unit.sv
// self-checking bench for the mac prefetch/write-back unit
// assumes the memory model and the port checker beside the unit
`timescale 1ns/1ps
`default_nettype none
module tb_dmpw_unit;
  logic sys_clk_in, sys_rst_in, op_valid_in, op_acc_sel_in, x_pf_ptr_in;
  logic y_pf_ptr_in, frac_int_mode_in, sfr_rd_in, sfr_wr_in, dbl_load_in;
  logic dbl_store_in, dbl_acc_in, x_rd_out, y_rd_out, xptr_wr_out;
  logic xptr_sel_out, yptr_wr_out, yptr_sel_out, pf_x_wr_out, pf_y_wr_out;
  logic wb_mem_wr_out, w13_wr_out, acc_a_overflow_flag_out, op_err_out;
  logic acc_b_overflow_flag_out, acc_a_saturated_flag_out;
  logic acc_b_saturated_flag_out;
  logic [1:0] op_mul_a_in, op_mul_b_in, x_pf_mode_in, x_pf_dst_in;
  logic [1:0] y_pf_mode_in, y_pf_dst_in, wb_mode_in, sat_mode_in;
  logic [1:0] sat_flag_clr_in, sfr_be_in, pf_x_dst_out, pf_y_dst_out;
  logic [2:0] op_code_in, x_pf_mod_in, y_pf_mod_in, sfr_sel_in;
  logic [15:0] w4_in, w5_in, w6_in, w7_in, w8_in, w9_in, w10_in, w11_in;
  logic [15:0] w12_in, w13_in, x_rdata_in, y_rdata_in, sfr_wdata_in;
  logic [15:0] x_addr_out, y_addr_out, xptr_val_out, yptr_val_out;
  logic [15:0] pf_x_val_out, pf_y_val_out, wb_addr_out, wb_data_out;
  logic [15:0] w13_val_out, sfr_rdata_out;
  logic [31:0] dbl_wdata_in, dbl_rdata_out;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  dmpw_unit i_dmpw_unit (.*);
  dmpw_mem_model i_dmpw_mem_model (.*);

  // ----------
  // helpers
  // ----------
  task automatic chk(input string n, input logic [39:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // returns while the answer pulses stand
  task automatic fire;
    @(negedge sys_clk_in) op_valid_in = 1'h1;
    @(negedge sys_clk_in) op_valid_in = 1'h0;
  endtask : fire

  task automatic set_op(input logic [2:0] c, input logic s,
                        input logic [1:0] a, b, w);
    {op_code_in, op_acc_sel_in, op_mul_a_in, op_mul_b_in} = {c, s, a, b};
    wb_mode_in = w;
  endtask : set_op

  task automatic set_pf(input logic [7:0] xc, yc);
    {x_pf_mode_in, x_pf_ptr_in, x_pf_mod_in, x_pf_dst_in} = xc;
    {y_pf_mode_in, y_pf_ptr_in, y_pf_mod_in, y_pf_dst_in} = yc;
  endtask : set_pf

  task automatic sfr_w(input logic [2:0] s, input logic [15:0] d);
    @(negedge sys_clk_in);
    {sfr_sel_in, sfr_wdata_in, sfr_wr_in} = {s, d, 1'h1};
    @(negedge sys_clk_in) sfr_wr_in = 1'h0;
  endtask : sfr_w

  task automatic sfr_r(input logic [2:0] s, input logic [15:0] e);
    @(negedge sys_clk_in);
    {sfr_sel_in, sfr_rd_in} = {s, 1'h1};
    @(negedge sys_clk_in) sfr_rd_in = 1'h0;
    @(negedge sys_clk_in) chk("sfr read", e, sfr_rdata_out);
  endtask : sfr_r

  initial begin
    sys_clk_in = 1'h0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // about 125 cycles expected, wide margin
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim;
    end
  end

  // ----------
  // sequence
  // ----------
  initial begin
    {op_valid_in, sfr_rd_in, sfr_wr_in, dbl_load_in, dbl_store_in} = '0;
    {dbl_acc_in, sat_mode_in, sat_flag_clr_in, frac_int_mode_in} = '0;
    {sfr_sel_in, sfr_wdata_in, dbl_wdata_in, sfr_be_in} = {51'h0, 2'h3};
    set_op(3'h0, 1'h0, 2'h0, 2'h0, 2'h0);
    set_pf(8'h00, 8'h00);
    {w4_in, w5_in, w6_in, w7_in} = 64'h0003_fffe_4000_0001;
    {w8_in, w9_in, w10_in, w11_in} = 64'h0100_0200_0300_0400;
    {w12_in, w13_in} = 32'hfffc_0800;
    sys_rst_in = 1'h1;
    repeat (10) @(negedge sys_clk_in);
    sys_rst_in = 1'h0;
    sfr_w(dmpw_pkg::SFR_B_HIGH, 16'h1234);
    sfr_w(dmpw_pkg::SFR_B_LOW, 16'h8000);
    frac_int_mode_in = 1'h1;
    set_op(dmpw_pkg::OP_MAC, 1'h0, 2'h0, 2'h1, dmpw_pkg::WB_INDIRECT);
    set_pf(8'h4e, 8'h77);
    fire;
    chk("x read", 17'h1_0100, {x_rd_out, x_addr_out});
    chk("y read", 17'h1_0400, {y_rd_out, y_addr_out});
    chk("xptr", 18'h2_0106, {xptr_wr_out, xptr_sel_out, xptr_val_out});
    chk("yptr", 18'h3_03fa, {yptr_wr_out, yptr_sel_out, yptr_val_out});
    chk("wb", 33'h1_0800_1235, {wb_mem_wr_out, wb_addr_out, wb_data_out});
    chk("w13", 17'h1_0802, {w13_wr_out, w13_val_out});
    @(negedge sys_clk_in);
    chk("pf x", 19'h6_0200, {pf_x_wr_out, pf_x_dst_out, pf_x_val_out});
    chk("pf y", 19'h7_0300, {pf_y_wr_out, pf_y_dst_out, pf_y_val_out});
    sfr_r(dmpw_pkg::SFR_A_HIGH, 16'hffff);
    sfr_r(dmpw_pkg::SFR_A_LOW, 16'hfffa);
    sfr_r(dmpw_pkg::SFR_A_UPPER, 16'hffff);
    frac_int_mode_in = 1'h0;
    set_op(dmpw_pkg::OP_MUL, 1'h1, 2'h2, 2'h2, dmpw_pkg::WB_NONE);
    set_pf(8'ha0, 8'h00);
    fire;
    chk("offset", 18'h2_01fc, {x_rd_out, xptr_wr_out, x_addr_out});
    sfr_r(dmpw_pkg::SFR_B_HIGH, 16'h2000);
    sfr_r(dmpw_pkg::SFR_B_LOW, 16'h0000);
    set_op(dmpw_pkg::OP_EDIST, 1'h0, 2'h0, 2'h0, dmpw_pkg::WB_NONE);
    set_pf(8'h41, 8'h61);
    fire;
    @(negedge sys_clk_in);
    chk("ed", 20'ha_ff00, {pf_x_wr_out, pf_x_dst_out, pf_y_wr_out,
                           pf_x_val_out});
    set_op(dmpw_pkg::OP_CLR, 1'h0, 2'h0, 2'h0, dmpw_pkg::WB_DIRECT);
    set_pf(8'h00, 8'h00);
    fire;
    chk("clr", 18'h1_2000, {wb_mem_wr_out, w13_wr_out, w13_val_out});
    sfr_r(dmpw_pkg::SFR_A_HIGH, 16'h0000);
    set_op(dmpw_pkg::OP_MOVSTORE, 1'h1, 2'h0, 2'h0, dmpw_pkg::WB_INDIRECT);
    fire;
    chk("mov", 33'h1_0800_0000, {wb_mem_wr_out, wb_addr_out, wb_data_out});
    sfr_r(dmpw_pkg::SFR_B_HIGH, 16'h2000);
    for (int i = 0; i < 6; i++) begin
      sfr_w(3'(i), 16'h3c50 + 16'(i));
      sfr_r(3'(i), (i % 3 == 0) ? 16'h0050 + 16'(i) : 16'h3c50 + 16'(i));
    end
    chk("flags", 4'h0, {acc_a_overflow_flag_out, acc_b_overflow_flag_out,
        acc_a_saturated_flag_out, acc_b_saturated_flag_out});
    sfr_w(dmpw_pkg::SFR_A_UPPER, 16'h0080);
    sfr_r(dmpw_pkg::SFR_A_UPPER, 16'hff80);
    sfr_r(3'h6, 16'h0000);
    {dbl_acc_in, dbl_wdata_in} = {1'h1, 32'h8000_0001};
    @(negedge sys_clk_in) dbl_load_in = 1'h1;
    @(negedge sys_clk_in) {dbl_load_in, dbl_store_in} = 2'h1;
    @(negedge sys_clk_in) dbl_store_in = 1'h0;
    @(negedge sys_clk_in) chk("dbl", 32'h8000_0001, dbl_rdata_out);
    sfr_r(dmpw_pkg::SFR_B_UPPER, 16'hffff);
    set_pf(8'h41, 8'h42);
    sat_mode_in = dmpw_pkg::SAT_NORMAL;
    set_op(dmpw_pkg::OP_MSUB, 1'h1, 2'h0, 2'h0, dmpw_pkg::WB_NONE);
    fire;
    chk("sat b", 1'h1, acc_b_saturated_flag_out);
    sfr_r(dmpw_pkg::SFR_B_HIGH, 16'h8000);
    for (int i = 0; i < 8; i++) begin
      set_op(3'(i), 1'h0, 2'h0, 2'h0, dmpw_pkg::WB_NONE);
      fire;
      chk("taken", 3'h6, {x_rd_out, y_rd_out, op_err_out});
    end
    for (int i = 0; i < 5; i++) begin
      set_op(dmpw_pkg::OP_MAC, 1'h0, 2'h0, 2'h1, dmpw_pkg::WB_NONE);
      case (i)
        0: x_pf_mode_in = dmpw_pkg::PF_OFFSET;
        1: x_pf_mod_in = dmpw_pkg::PF_MOD_BAD;
        2: {op_code_in, wb_mode_in} = {dmpw_pkg::OP_MUL, dmpw_pkg::WB_DIRECT};
        3: op_code_in = dmpw_pkg::OP_EDIST;
        default: {op_mul_b_in, wb_mode_in} = {2'h0, dmpw_pkg::WB_DIRECT};
      endcase
      fire;
      chk("refused", 4'h8, {op_err_out, x_rd_out, wb_mem_wr_out,
          w13_wr_out});
      set_pf(8'h41, 8'h42);
    end
    end_sim;
  end
endmodule : tb_dmpw_unit

bind dmpw_unit dmpw_props i_dmpw_props (.*);
`default_nettype wire
